// [dbsb_pkg.sv]
// Constants, command codes and carrier types for the debug status/breakpoint block.
// Assumes a serial command decoder outside presents decoded commands one per cycle.
package dbsb_pkg;
  localparam int unsigned STAT_W = 8;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned BIT_ALLOW = 7;
  localparam int unsigned BIT_ACTIVE = 6;
  localparam int unsigned BIT_BKPT_EN = 5;
  localparam int unsigned BIT_FORCE = 4;
  localparam int unsigned BIT_CLKSEL = 3;
  localparam int unsigned BIT_WS = 2;
  localparam int unsigned BIT_WSF = 1;
  localparam int unsigned BIT_DVF = 0;
  localparam logic [7:0] SCR_RESET = 8'h00;
  localparam logic [15:0] BKPT_RESET = 16'h0000;
  // Which bits a store command may change
  localparam logic [7:0] SCR_WR_MASK = 8'hb8;

  typedef enum logic [2:0] {
    DBSB_CMD_NONE = 3'b000,
    DBSB_CMD_FETCH_CTRL = 3'b001,
    DBSB_CMD_STORE_CTRL = 3'b010,
    DBSB_CMD_FETCH_BKPT = 3'b011,
    DBSB_CMD_STORE_BKPT = 3'b100,
    DBSB_CMD_ENTER_HALT = 3'b101
  } dbsb_cmd_e;

  typedef struct packed {
    dbsb_cmd_e cmd;
    logic [15:0] wdata;
  } dbsb_req_s;

  typedef struct packed {
    logic [15:0] addr;
    logic fetch;
    logic boundary;
    logic queue_end_tagged;
    logic in_wait_stop;
    logic mem_fail_ws;
  } dbsb_cpu_s;
endpackage

// [dbsb_match.sv]
// Breakpoint address comparator producing force or tag requests.
// Assumes the CPU address bus is synchronous to clk.
`timescale 1ns/10ps
module dbsb_match (
  input wire logic enable,
  input wire logic force_sel,
  input wire logic [15:0] match_addr,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_fetch,
  output logic force_hit,
  output logic tag_hit
);
  logic hit;
  always_comb
  begin
    hit = enable && (cpu_addr == match_addr);
    force_hit = hit && force_sel;
    tag_hit = hit && !force_sel && cpu_fetch;
  end
endmodule // dbsb_match

// [dbsb_ctrl.sv]
// Status/control and breakpoint storage of the serial debug controller.
// Assumes decoded serial commands and CPU status arrive synchronous to clk.
`timescale 1ns/10ps
module dbsb_ctrl (
  input wire logic clk,
  input wire logic resetn,
  input dbsb_pkg::dbsb_req_s req,
  input dbsb_pkg::dbsb_cpu_s cpu,
  input wire logic resume,
  output logic [15:0] rdata_q,
  output logic rvalid_q,
  output logic halt_active,
  output logic halt_request,
  output logic tag_opcode,
  output logic wake_cpu,
  output logic comm_clock_select
);
  logic allow_q, allow_d;
  logic active_q, active_d;
  logic bken_q, bken_d;
  logic force_q, force_d;
  logic clksel_q, clksel_d;
  logic ws_q, ws_d;
  logic wsf_q, wsf_d;
  logic pend_q, pend_d;
  logic [15:0] bkpt_q, bkpt_d;
  logic [15:0] rdata_d;
  logic rvalid_d;
  logic [7:0] scr;
  logic force_hit;
  logic tag_hit;
  logic enter;

  dbsb_match u_match (
    .enable(bken_q),
    .force_sel(force_q),
    .match_addr(bkpt_q),
    .cpu_addr(cpu.addr),
    .cpu_fetch(cpu.fetch),
    .force_hit(force_hit),
    .tag_hit(tag_hit)
  );

  always_comb
  begin
    scr = 8'h00;
    scr[dbsb_pkg::BIT_ALLOW] = allow_q;
    scr[dbsb_pkg::BIT_ACTIVE] = active_q;
    scr[dbsb_pkg::BIT_BKPT_EN] = bken_q;
    scr[dbsb_pkg::BIT_FORCE] = force_q;
    scr[dbsb_pkg::BIT_CLKSEL] = clksel_q;
    scr[dbsb_pkg::BIT_WS] = ws_q;
    scr[dbsb_pkg::BIT_WSF] = wsf_q;
    scr[dbsb_pkg::BIT_DVF] = 1'b0;
  end

  // Halt entry sources; all gated by the allow bit
  always_comb
  begin
    enter = allow_q && !active_q &&
            ((pend_q && cpu.boundary) || cpu.queue_end_tagged ||
             (req.cmd == dbsb_pkg::DBSB_CMD_ENTER_HALT));
  end

  always_comb
  begin
    allow_d = allow_q;
    active_d = active_q;
    bken_d = bken_q;
    force_d = force_q;
    clksel_d = clksel_q;
    ws_d = ws_q;
    wsf_d = wsf_q;
    pend_d = pend_q;
    bkpt_d = bkpt_q;
    rdata_d = rdata_q;
    rvalid_d = 1'b0;
    if (force_hit && allow_q && !active_q)
    begin
      pend_d = 1'b1;
    end
    if (enter)
    begin
      active_d = 1'b1;
      pend_d = 1'b0;
      ws_d = cpu.in_wait_stop;
    end
    else if (active_q && resume)
    begin
      active_d = 1'b0;
      ws_d = 1'b0;
    end
    else if (!active_q)
    begin
      ws_d = cpu.in_wait_stop;
    end
    case (req.cmd)
      dbsb_pkg::DBSB_CMD_FETCH_CTRL:
      begin
        rdata_d = {8'h00, scr};
        rvalid_d = 1'b1;
      end
      dbsb_pkg::DBSB_CMD_STORE_CTRL:
      begin
        if (!active_q)
        begin
          allow_d = req.wdata[dbsb_pkg::BIT_ALLOW];
        end
        bken_d = req.wdata[dbsb_pkg::BIT_BKPT_EN];
        force_d = req.wdata[dbsb_pkg::BIT_FORCE];
        clksel_d = req.wdata[dbsb_pkg::BIT_CLKSEL];
      end
      dbsb_pkg::DBSB_CMD_FETCH_BKPT:
      begin
        rdata_d = bkpt_q;
        rvalid_d = 1'b1;
      end
      dbsb_pkg::DBSB_CMD_STORE_BKPT:
      begin
        bkpt_d = req.wdata;
      end
      default:
      begin
        rvalid_d = 1'b0;
      end
    endcase
    // A new failure wins over the clear made by entering halt
    if (cpu.mem_fail_ws)
    begin
      wsf_d = 1'b1;
    end
    else if (enter)
    begin
      wsf_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      allow_q <= 1'b0;
      active_q <= 1'b0;
      bken_q <= 1'b0;
      force_q <= 1'b0;
      clksel_q <= 1'b0;
      ws_q <= 1'b0;
      wsf_q <= 1'b0;
      pend_q <= 1'b0;
      bkpt_q <= dbsb_pkg::BKPT_RESET;
      rdata_q <= 16'h0000;
      rvalid_q <= 1'b0;
    end
    else
    begin
      allow_q <= allow_d;
      active_q <= active_d;
      bken_q <= bken_d;
      force_q <= force_d;
      clksel_q <= clksel_d;
      ws_q <= ws_d;
      wsf_q <= wsf_d;
      pend_q <= pend_d;
      bkpt_q <= bkpt_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign halt_active = active_q;
  assign halt_request = enter;
  assign tag_opcode = tag_hit && allow_q;
  assign wake_cpu = enter && cpu.in_wait_stop;
  assign comm_clock_select = clksel_q;

  a_allow_gates_halt: assert property (@(posedge clk) disable iff (!resetn)
    (!allow_q && !active_q) |=> !active_q) else $error("halt entered while not allowed");
  a_active_readback: assert property (@(posedge clk) disable iff (!resetn)
    req.cmd == dbsb_pkg::DBSB_CMD_FETCH_CTRL |=>
    rdata_q[dbsb_pkg::BIT_ACTIVE] == $past(active_q))
    else $error("active flag readback wrong");
  a_disabled_no_bkpt: assert property (@(posedge clk) disable iff (!resetn)
    !bken_q |-> !force_hit && !tag_hit) else $error("breakpoint while disabled");
  a_force_halts: assert property (@(posedge clk) disable iff (!resetn)
    (force_hit && allow_q && !active_q && !enter) ##1
    (cpu.boundary && !active_q) |=> active_q)
    else $error("force match did not halt");
  a_tag_marks: assert property (@(posedge clk) disable iff (!resetn)
    (bken_q && !force_q && allow_q && cpu.fetch && cpu.addr == bkpt_q) |-> tag_opcode)
    else $error("matching fetch not tagged");
  a_clksel_store: assert property (@(posedge clk) disable iff (!resetn)
    req.cmd == dbsb_pkg::DBSB_CMD_STORE_CTRL |=>
    clksel_q == $past(req.wdata[dbsb_pkg::BIT_CLKSEL]))
    else $error("clock select not stored");
  a_ws_tracks: assert property (@(posedge clk) disable iff (!resetn)
    !active_q |=> ws_q == $past(cpu.in_wait_stop)) else $error("wait/stop flag wrong");
  a_halt_wakes: assert property (@(posedge clk) disable iff (!resetn)
    (req.cmd == dbsb_pkg::DBSB_CMD_ENTER_HALT && allow_q && !active_q && cpu.in_wait_stop)
    |-> wake_cpu ##1 (active_q && ws_q)) else $error("halt from wait/stop failed");
  a_wsf_sets: assert property (@(posedge clk) disable iff (!resetn)
    cpu.mem_fail_ws |=> wsf_q) else $error("wait/stop failure not flagged");
  a_dvf_zero: assert property (@(posedge clk) disable iff (!resetn)
    rvalid_q && $past(req.cmd) == dbsb_pkg::DBSB_CMD_FETCH_CTRL |->
    !rdata_q[dbsb_pkg::BIT_DVF])
    else $error("data valid failure nonzero");
  a_read_by_cmd: assert property (@(posedge clk) disable iff (!resetn)
    rvalid_q |-> ($past(req.cmd) == dbsb_pkg::DBSB_CMD_FETCH_CTRL ||
    $past(req.cmd) == dbsb_pkg::DBSB_CMD_FETCH_BKPT))
    else $error("read data without fetch command");
  a_bkpt_store: assert property (@(posedge clk) disable iff (!resetn)
    req.cmd == dbsb_pkg::DBSB_CMD_STORE_BKPT |=> bkpt_q == $past(req.wdata))
    else $error("match address not stored");
  a_allow_locked: assert property (@(posedge clk) disable iff (!resetn)
    active_q && !resume |=> $stable(allow_q)) else $error("allow bit changed in halt");
endmodule // dbsb_ctrl

// [dbsb_host.sv]
// Debug host model issuing decoded serial commands one at a time.
// Assumes the block takes a command on the rising edge after it is driven.
`timescale 1ns/10ps
module dbsb_host (
  input wire logic clk,
  input wire logic [15:0] rdata_q,
  output dbsb_pkg::dbsb_req_s req
);
  initial req = '0;
  // Released data shows its inverse so a stale value is never mistaken for a store
  task automatic xfer(input dbsb_pkg::dbsb_cmd_e c, input logic [15:0] d,
    output logic [15:0] rd);
    @(negedge clk);
    req.cmd = c;
    req.wdata = d;
    @(negedge clk);
    rd = rdata_q;
    req.cmd = dbsb_pkg::DBSB_CMD_NONE;
    req.wdata = ~d;
  endtask
endmodule // dbsb_host

// [tb.sv]
// Self-checking bench for the debug status/breakpoint block.
// Assumes dbsb_host drives commands; CPU status changes on falling edges.
`timescale 1ns/10ps
module tb;
  localparam dbsb_pkg::dbsb_cmd_e FC = dbsb_pkg::DBSB_CMD_FETCH_CTRL;
  localparam dbsb_pkg::dbsb_cmd_e SC = dbsb_pkg::DBSB_CMD_STORE_CTRL;
  localparam dbsb_pkg::dbsb_cmd_e FB = dbsb_pkg::DBSB_CMD_FETCH_BKPT;
  localparam dbsb_pkg::dbsb_cmd_e SB = dbsb_pkg::DBSB_CMD_STORE_BKPT;
  localparam dbsb_pkg::dbsb_cmd_e EH = dbsb_pkg::DBSB_CMD_ENTER_HALT;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic resume = 1'b0;
  dbsb_pkg::dbsb_cpu_s cpu = '{addr: 16'hffff, default: 1'b0};
  dbsb_pkg::dbsb_req_s req;
  logic [15:0] rdata_q, rd, a, w;
  logic rvalid_q, halt_active, halt_request, tag_opcode, wake_cpu, comm_clock_select;
  int seed = 32'h7898;
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  dbsb_ctrl u_dbsb_ctrl (.clk(clk), .resetn(resetn), .req(req), .cpu(cpu), .resume(resume),
    .rdata_q(rdata_q), .rvalid_q(rvalid_q), .halt_active(halt_active),
    .halt_request(halt_request), .tag_opcode(tag_opcode), .wake_cpu(wake_cpu),
    .comm_clock_select(comm_clock_select));
  dbsb_host u_dbsb_host (.clk(clk), .rdata_q(rdata_q), .req(req));
  initial
  begin
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      err_total++;
      stop_test();
    end
  end
  task automatic stop_test;
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_halt(input logic e);
    chk({15'h0, halt_active}, {15'h0, e});
  endtask
  function automatic logic [15:0] scr_exp(input logic [7:0] v);
    return {8'h00, v & dbsb_pkg::SCR_WR_MASK};
  endfunction
  task automatic cmd(input dbsb_pkg::dbsb_cmd_e c, input logic [15:0] d);
    u_dbsb_host.xfer(c, d, rd);
  endtask
  task automatic go;
    @(negedge clk) resume = 1'b1;
    @(negedge clk) resume = 1'b0;
  endtask
  // Entry strobes are combinational, so look while the command still stands
  task automatic enter_halt(input logic exp_req, input logic exp_wake);
    fork
      cmd(EH, 16'h0);
      begin
        @(negedge clk);
        #1 chk({15'h0, halt_request}, {15'h0, exp_req});
        chk({15'h0, wake_cpu}, {15'h0, exp_wake});
      end
    join
  endtask
  // Address match then a boundary one cycle later
  task automatic hit;
    @(negedge clk) cpu.addr = a;
    @(negedge clk)
    begin
      cpu.addr = ~a;
      cpu.boundary = 1'b1;
    end
    @(negedge clk) cpu.boundary = 1'b0;
    @(negedge clk);
  endtask
  initial
  begin
    repeat (8) @(negedge clk);
    resetn = 1'b1;
    cmd(FC, 16'h0);
    chk(rd, 16'h0000);
    for (int i = 0; i < 6; i++)
    begin
      w = 16'($random(seed));
      cmd(SC, w);
      cmd(FC, 16'h0);
      chk(rd, scr_exp(w[7:0]));
      chk({15'h0, comm_clock_select}, {15'h0, w[3]});
      cmd(SB, w ^ 16'h5a5a);
      chk({15'h0, rvalid_q}, 16'h0);
      cmd(FB, 16'h0);
      chk({15'h0, rvalid_q}, 16'h1);
      chk(rd, w ^ 16'h5a5a);
    end
    cmd(SC, 16'h0000);
    enter_halt(1'b0, 1'b0);
    chk_halt(1'b0);
    cmd(SC, 16'h0080);
    cpu.in_wait_stop = 1'b1;
    enter_halt(1'b1, 1'b1);
    cpu.in_wait_stop = 1'b0;
    cmd(FC, 16'h0);
    chk(rd, 16'h00c4);
    cmd(SC, 16'h0008);
    cmd(FC, 16'h0);
    chk(rd, 16'h00cc);
    go();
    chk_halt(1'b0);
    cpu.mem_fail_ws = 1'b1;
    @(negedge clk) cpu.mem_fail_ws = 1'b0;
    cmd(FC, 16'h0);
    chk(rd, 16'h008a);
    enter_halt(1'b1, 1'b0);
    cmd(FC, 16'h0);
    chk(rd, 16'h00c8);
    a = 16'($random(seed));
    cmd(SB, a);
    cmd(SC, 16'h00a0);
    go();
    @(negedge clk)
    begin
      cpu.addr = a;
      cpu.fetch = 1'b1;
    end
    #1 chk({15'h0, tag_opcode}, 16'h1);
    @(negedge clk)
    begin
      cpu.fetch = 1'b0;
      cpu.addr = ~a;
      cpu.queue_end_tagged = 1'b1;
    end
    chk_halt(1'b0);
    #1 chk({15'h0, halt_request}, 16'h1);
    @(negedge clk) cpu.queue_end_tagged = 1'b0;
    chk_halt(1'b1);
    go();
    cmd(SC, 16'h0090);
    hit();
    chk_halt(1'b0);
    cmd(SC, 16'h00b0);
    hit();
    chk_halt(1'b1);
    // Normal reset in mid-run must clear the allow bit and the match address
    @(negedge clk) resetn = 1'b0;
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    chk_halt(1'b0);
    cmd(FC, 16'h0);
    chk(rd, {8'h00, dbsb_pkg::SCR_RESET});
    cmd(FB, 16'h0);
    chk(rd, dbsb_pkg::BKPT_RESET);
    stop_test();
  end
endmodule // tb
